// file: design/irq_enable_priority.sv
// interrupt enable, priority and extended flag registers
//
// How it works
// R01: standard enable bit 4 gates serial port
// R02: standard enable bit 3 gates timer 1
// R03: standard enable bit 2 gates external 1
// R04: standard enable bit 1 gates timer 0
// R05: standard enable bit 0 gates external 0
// R06: standard priority bits 5..0 choose levels
// R07: rx2 ready rising edge sets flag 7
// R08: software writing one sets pending flag
// R09: rx1 ready rising edge sets flag 6
// R10: spi byte done sets flag 5
// R11: conversion done rising edge sets flag 4
// R12: wakeup event sets sticky wakeup flag
// R13: software setting wakeup flag raises request
// R14: extended enable bit 4 gates wakeup
// R15: extended enable bits 3..0 gate sources
// R16: extended priority bit 4 sets wakeup level
// R17: extended priority bits 3..0 set levels
// R18: global enable clear masks everything
// R19: level first, then natural rank
// R20: preempt only by strictly higher level
// R21: hardware set beats software clear
`timescale 1ns/1ns
module irq_enable_priority (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // special function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // standard source flags, kept by their peripherals
  input  wire logic       ext0_flag,
  input  wire logic       timer0_overflow,
  input  wire logic       ext1_flag,
  input  wire logic       timer1_overflow,
  input  wire logic       serial_tx_flag,
  input  wire logic       serial_rx_flag,
  input  wire logic       timer2_overflow,
  // extended source signals
  input  wire logic       conv_eoc,
  input  wire logic       spi_byte_done,
  input  wire logic       rx1_data_ready,
  input  wire logic       rx2_data_ready,
  input  wire logic       wakeup_event,
  // core handshake
  input  wire logic       isr_enter,
  input  wire logic       isr_return,
  output logic            irq_req,
  output logic      [3:0] irq_src,
  output logic            irq_high
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] std_en;
    logic [5:0] std_pri;
    logic [3:0] ext_flags;
    logic       wake_flag;
    logic [4:0] ext_en;
    logic [4:0] ext_pri;
    logic [3:0] edge_prev;
    logic       svc_low;
    logic       svc_high;
    logic [7:0] rdata;
    logic       req;
    logic [3:0] src;
    logic       high;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // reset image: nothing pending, nothing in service, no source offered
  localparam state_t ST_RST = '{
    std_en:    irq_pkg::STD_EN_RST,
    std_pri:   irq_pkg::STD_PRI_RST,
    ext_flags: '0,
    wake_flag: '0,
    ext_en:    irq_pkg::EXT_EN_RST,
    ext_pri:   irq_pkg::EXT_PRI_RST,
    edge_prev: '0,
    svc_low:   '0,
    svc_high:  '0,
    rdata:     '0,
    req:       '0,
    src:       irq_pkg::SRC_NONE,
    high:      '0
  };

  logic [irq_pkg::NUM_SRC-1:0] pend;
  logic [irq_pkg::NUM_SRC-1:0] en;
  logic [irq_pkg::NUM_SRC-1:0] lvl;
  logic [3:0]                  edges;
  logic [3:0]                  hw_set;
  logic [3:0]                  sel_hi;
  logic [3:0]                  sel_lo;
  logic                        any_hi;
  logic                        any_lo;

  // ------------------------------------------------------------
  // source vectors, natural rank order
  // ------------------------------------------------------------
  always_comb begin
    edges = {rx2_data_ready, rx1_data_ready, spi_byte_done, conv_eoc};
    // history resets low, so a source high at release counts as an edge
    // R11 conversion edge
    hw_set[0] = edges[0] & ~st_r.edge_prev[0];
    // R10 spi byte done
    hw_set[1] = edges[1] & ~st_r.edge_prev[1];
    // R09 rx1 edge
    hw_set[2] = edges[2] & ~st_r.edge_prev[2];
    // R07 rx2 edge
    hw_set[3] = edges[3] & ~st_r.edge_prev[3];

    pend[0]   = ext0_flag;
    pend[1]   = timer0_overflow;
    pend[2]   = ext1_flag;
    pend[3]   = timer1_overflow;
    // R01 either serial flag
    pend[4]   = serial_tx_flag | serial_rx_flag;
    pend[5]   = timer2_overflow;
    // R08 stored flags pend
    pend[9:6] = st_r.ext_flags;
    // R13 wakeup flag pends
    pend[10]  = st_r.wake_flag;

    // R05 ext0 gate
    en[0]   = st_r.std_en[0];
    // R04 timer0 gate
    en[1]   = st_r.std_en[1];
    // R03 ext1 gate
    en[2]   = st_r.std_en[2];
    // R02 timer1 gate
    en[3]   = st_r.std_en[3];
    // R01 serial gate
    en[4]   = st_r.std_en[4];
    // timer 2 gated like the others
    en[5]   = st_r.std_en[5];
    // R15 extended gates
    en[9:6] = st_r.ext_en[3:0];
    // R14 wakeup gate
    en[10]  = st_r.ext_en[4];

    // R06 standard levels
    lvl[5:0] = st_r.std_pri;
    // R17 extended levels
    lvl[9:6] = st_r.ext_pri[3:0];
    // R16 wakeup level
    lvl[10]  = st_r.ext_pri[4];
  end

  // ------------------------------------------------------------
  // arbitration
  // ------------------------------------------------------------
  always_comb begin
    logic [irq_pkg::NUM_SRC-1:0] act;
    act    = '0;
    sel_hi = irq_pkg::SRC_NONE;
    sel_lo = irq_pkg::SRC_NONE;
    any_hi = 1'b0;
    any_lo = 1'b0;
    // R18 global mask
    if (st_r.std_en[irq_pkg::GLOBAL_EN_BIT]) begin
      act = pend & en;
    end
    // one scan serves both levels; the high pick is offered first later
    // R19 lowest index wins within a level
    for (int i = irq_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (act[i] && lvl[i]) begin
        sel_hi = 4'(i);
        any_hi = 1'b1;
      end
      if (act[i] && !lvl[i]) begin
        sel_lo = 4'(i);
        any_lo = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic wr_flags;
    logic wr_ctrl;
    wr_flags = sfr_wr && sfr_addr == irq_pkg::EXT_FLAGS_ADDR;
    wr_ctrl  = sfr_wr && sfr_addr == irq_pkg::EXT_CTRL_ADDR;
    st_nxt           = st_r;
    // edge history follows the source lines every cycle
    st_nxt.edge_prev = edges;

    if (sfr_wr && sfr_addr == irq_pkg::STD_EN_ADDR) begin
      st_nxt.std_en = sfr_wdata & irq_pkg::STD_EN_MASK;
    end
    if (sfr_wr && sfr_addr == irq_pkg::STD_PRI_ADDR) begin
      st_nxt.std_pri = sfr_wdata[5:0];
    end
    if (sfr_wr && sfr_addr == irq_pkg::EXT_EN_ADDR) begin
      st_nxt.ext_en = sfr_wdata[4:0];
    end
    if (sfr_wr && sfr_addr == irq_pkg::EXT_PRI_ADDR) begin
      st_nxt.ext_pri = sfr_wdata[4:0];
    end

    // R08 written ones become pending requests
    if (wr_flags) begin
      st_nxt.ext_flags = sfr_wdata[7:irq_pkg::EXT_FLAG_LSB];
    end
    // R21 edge set overrides a same-cycle clear
    st_nxt.ext_flags = st_nxt.ext_flags | hw_set;

    // R13 written one raises wakeup request
    if (wr_ctrl) begin
      st_nxt.wake_flag = sfr_wdata[irq_pkg::WAKE_FLAG_BIT];
    end
    // R12 sticky until software clears
    // R21 event beats clear
    // a level, not an edge: every cycle of the event sets the flag
    if (wakeup_event) begin
      st_nxt.wake_flag = 1'b1;
    end

    // one level of nesting per level; a return unwinds the higher one
    // a return and an entry in one cycle: the return wins
    if (isr_return) begin
      if (st_r.svc_high) begin
        st_nxt.svc_high = 1'b0;
      end else begin
        st_nxt.svc_low = 1'b0;
      end
    end else if (isr_enter && st_r.req) begin
      if (st_r.high) begin
        st_nxt.svc_high = 1'b1;
      end else begin
        st_nxt.svc_low = 1'b1;
      end
    end

    // the high pick needs only the high level free
    // R20 only a strictly higher level preempts
    st_nxt.req  = 1'b0;
    st_nxt.src  = irq_pkg::SRC_NONE;
    st_nxt.high = 1'b0;
    if (!st_nxt.svc_high && any_hi) begin
      st_nxt.req  = 1'b1;
      st_nxt.src  = sel_hi;
      st_nxt.high = 1'b1;
    end else if (!st_nxt.svc_high && !st_nxt.svc_low && any_lo) begin
      st_nxt.req = 1'b1;
      st_nxt.src = sel_lo;
    end

    // read data, reserved bits at their fixed values
    // registered: one cycle late, but the bus output is a flop
    if (sfr_rd) begin
      unique case (sfr_addr)
        irq_pkg::EXT_FLAGS_ADDR:
          st_nxt.rdata = {st_r.ext_flags, 4'h0} | irq_pkg::EXT_FLAG_FIXED;
        irq_pkg::STD_EN_ADDR:
          st_nxt.rdata = st_r.std_en;
        irq_pkg::STD_PRI_ADDR:
          st_nxt.rdata = {2'h0, st_r.std_pri} | irq_pkg::STD_PRI_FIXED;
        irq_pkg::EXT_CTRL_ADDR:
          st_nxt.rdata = {4'h0, st_r.wake_flag, 3'h0} | irq_pkg::EXT_CTRL_FIXED;
        irq_pkg::EXT_EN_ADDR:
          st_nxt.rdata = {3'h0, st_r.ext_en} | irq_pkg::EXT_EN_FIXED;
        irq_pkg::EXT_PRI_ADDR:
          st_nxt.rdata = {3'h0, st_r.ext_pri} | irq_pkg::EXT_PRI_FIXED;
        default:
          st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs, each straight from its flop
  // ------------------------------------------------------------

  assign sfr_rdata = st_r.rdata;
  assign irq_req   = st_r.req;
  assign irq_src   = st_r.src;
  assign irq_high  = st_r.high;

endmodule : irq_enable_priority

// file: design/irq_pkg.sv
// shared constants of the interrupt enable and priority unit
package irq_pkg;
  // ------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------
  localparam logic [7:0] EXT_FLAGS_ADDR = 8'h91;
  localparam logic [7:0] STD_EN_ADDR    = 8'hA8;
  localparam logic [7:0] STD_PRI_ADDR   = 8'hB8;
  localparam logic [7:0] EXT_CTRL_ADDR  = 8'hD8;
  localparam logic [7:0] EXT_EN_ADDR    = 8'hE8;
  localparam logic [7:0] EXT_PRI_ADDR   = 8'hF8;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int GLOBAL_EN_BIT = 7;
  localparam int WAKE_FLAG_BIT = 3;
  localparam int EXT_FLAG_LSB  = 4;
  // ------------------------------------------------------------
  // reset values and fixed read bits
  // ------------------------------------------------------------
  localparam logic [7:0] STD_EN_RST     = 8'h00;
  localparam logic [5:0] STD_PRI_RST    = 6'h00;
  localparam logic [4:0] EXT_EN_RST     = 5'h00;
  localparam logic [4:0] EXT_PRI_RST    = 5'h00;
  localparam logic [7:0] STD_EN_MASK    = 8'hBF;
  localparam logic [7:0] STD_PRI_FIXED  = 8'h80;
  localparam logic [7:0] EXT_FLAG_FIXED = 8'h08;
  localparam logic [7:0] EXT_CTRL_FIXED = 8'h40;
  localparam logic [7:0] EXT_EN_FIXED   = 8'hE0;
  localparam logic [7:0] EXT_PRI_FIXED  = 8'hE0;
  // ------------------------------------------------------------
  // sources in natural rank order
  // ------------------------------------------------------------
  localparam int          NUM_SRC  = 11;
  localparam logic [3:0]  SRC_NONE = 4'hF;
endpackage : irq_pkg

// file: verif/irq_enable_priority_props.sv
// port checker for the interrupt enable and priority unit
`timescale 1ns/1ns
module irq_ep_props (
  // watched ports
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       conv_eoc,
  input wire logic       wakeup_event,
  input wire logic       isr_enter,
  input wire logic       irq_req,
  input wire logic [3:0] irq_src,
  input wire logic       irq_high
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  en_fixed_a: assert property (sfr_rd && sfr_addr == 8'hA8 |=> !sfr_rdata[6])
    else $error("enable bit 6 not zero");
  pri_fixed_a: assert property (sfr_rd && sfr_addr == 8'hB8 |=> sfr_rdata[7:6] == 2'h2)
    else $error("priority fixed bits wrong");
  flag_fixed_a: assert property (sfr_rd && sfr_addr == 8'h91 |=> sfr_rdata[3:0] == 4'h8)
    else $error("flag fixed bits wrong");
  ctrl_fixed_a: assert property (sfr_rd && sfr_addr == 8'hD8 |=> (sfr_rdata & 8'hF7) == 8'h40)
    else $error("control fixed bits wrong");
  ext_fixed_a: assert property (sfr_rd && (sfr_addr == 8'hE8 || sfr_addr == 8'hF8)
    |=> sfr_rdata[7:5] == 3'h7)
    else $error("extended fixed bits wrong");
  edge_flag_a: assert property ($rose(conv_eoc) ##1 (sfr_rd && sfr_addr == 8'h91)
    |=> sfr_rdata[4])
    else $error("conversion flag not set");
  wake_flag_a: assert property (wakeup_event ##1 (sfr_rd && sfr_addr == 8'hD8)
    |=> sfr_rdata[3])
    else $error("wakeup flag not set");
  global_off_a: assert property (sfr_wr && sfr_addr == 8'hA8 && !sfr_wdata[7]
    ##1 !(sfr_wr && sfr_addr == 8'hA8) |=> !irq_req)
    else $error("request with global enable off");
  high_svc_a: assert property (isr_enter && irq_req && irq_high |-> ##2 !irq_req)
    else $error("request during high service");
  low_svc_a: assert property (isr_enter && irq_req && !irq_high
    |-> ##2 (!irq_req || irq_high))
    else $error("low request during low service");
  src_code_a: assert property (irq_req ? irq_src < 4'hB : irq_src == 4'hF)
    else $error("source code out of range");
endmodule : irq_ep_props
bind irq_enable_priority irq_ep_props props_u (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .conv_eoc(conv_eoc), .wakeup_event(wakeup_event), .isr_enter(isr_enter),
  .irq_req(irq_req), .irq_src(irq_src), .irq_high(irq_high));

// file: verif/core_model.sv
// core side model: enters and leaves service routines
`timescale 1ns/1ns
module core_model (
  // clock, reset and commands
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic take,
  input  wire logic ret,
  // design handshake
  input  wire logic irq_req,
  output logic      isr_enter,
  output logic      isr_return
);
  // enter only on a standing request
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      isr_enter  <= 1'b0;
      isr_return <= 1'b0;
    end else begin
      isr_enter  <= #1 take & irq_req;
      isr_return <= #1 ret;
    end
  end
endmodule : core_model

// file: verif/irq_enable_priority_tb.sv
// self-checking bench for the interrupt enable and priority unit
`timescale 1ns/1ns
module irq_enable_priority_tb;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [6:0] std_f = 7'h00;
  logic [4:0] ext_s = 5'h00;
  logic       take = 1'b0;
  logic       ret = 1'b0;
  logic [7:0] rdata;
  logic       ent, rti, req, hi;
  logic [3:0] src;
  int         n_mismatch = 0;
  int         checks_done = 0;
  // register table: address, reset read, write, read after write
  logic [7:0] ta [7] = '{8'h91, 8'hA8, 8'hB8, 8'hD8, 8'hE8, 8'hF8, 8'h00};
  logic [7:0] tr [7] = '{8'h08, 8'h00, 8'h80, 8'h40, 8'hE0, 8'hE0, 8'h00};
  logic [7:0] tw [7] = '{8'hF0, 8'hFF, 8'hFF, 8'h08, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] tx [7] = '{8'hF8, 8'hBF, 8'hBF, 8'h48, 8'hFF, 8'hFF, 8'h00};
  always #5 clk = ~clk;
  irq_enable_priority dut_u (.clk(clk), .nrst(nrst), .sfr_addr(addr), .sfr_wr(wr),
    .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata), .ext0_flag(std_f[0]),
    .timer0_overflow(std_f[1]), .ext1_flag(std_f[2]), .timer1_overflow(std_f[3]),
    .serial_tx_flag(std_f[4]), .serial_rx_flag(std_f[5]), .timer2_overflow(std_f[6]),
    .conv_eoc(ext_s[0]), .spi_byte_done(ext_s[1]), .rx1_data_ready(ext_s[2]),
    .rx2_data_ready(ext_s[3]), .wakeup_event(ext_s[4]), .isr_enter(ent),
    .isr_return(rti), .irq_req(req), .irq_src(src), .irq_high(hi));
  core_model core_u (.clk(clk), .nrst(nrst), .take(take), .ret(ret), .irq_req(req),
    .isr_enter(ent), .isr_return(rti));
  task automatic check(string name, logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk) #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk) #1;
    wr = 1'b0;
  endtask : wr_reg
  // write that meets a source event at the same edge
  task automatic wr_race(logic [7:0] a, logic [7:0] d, logic [4:0] s);
    @(posedge clk) #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    ext_s = s;
    @(posedge clk) #1;
    wr = 1'b0;
    ext_s = 5'h00;
  endtask : wr_race
  task automatic rd_reg(logic [7:0] a, logic [7:0] e);
    @(posedge clk) #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk) #1;
    rd = 1'b0;
    check($sformatf("reg %h", a), rdata, e);
  endtask : rd_reg
  // outputs settle within two cycles; three are allowed
  task automatic req_is(logic r, logic [3:0] s, logic h);
    repeat (3) @(posedge clk);
    #1 check("request", {2'h0, req, src, hi}, {2'h0, r, s, h});
  endtask : req_is
  task automatic svc(logic t);
    @(posedge clk) #1;
    take = t;
    ret = ~t;
    @(posedge clk) #1;
    take = 1'b0;
    ret = 1'b0;
  endtask : svc
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd_reg(ta[i], tr[i]);
      wr_reg(ta[i], tw[i]);
      rd_reg(ta[i], tx[i]);
    end
    req_is(1'b1, 4'h6, 1'b1);
    wr_reg(8'h91, 8'h00);
    wr_reg(8'hD8, 8'h00);
    req_is(1'b0, 4'hF, 1'b0);
    std_f = 7'h7F;
    wr_reg(8'hB8, 8'h00);
    for (int k = 0; k < 6; k++) begin
      wr_reg(8'hA8, 8'h80 | (8'h01 << k));
      req_is(1'b1, k[3:0], 1'b0);
      wr_reg(8'hA8, 8'hBF);
      wr_reg(8'hB8, 8'h01 << k);
      req_is(1'b1, k[3:0], 1'b1);
      wr_reg(8'hB8, 8'h00);
    end
    std_f = 7'h20;
    wr_reg(8'hA8, 8'h90);
    req_is(1'b1, 4'h4, 1'b0);
    wr_reg(8'hA8, 8'h3F);
    req_is(1'b0, 4'hF, 1'b0);
    std_f = 7'h00;
    wr_reg(8'hA8, 8'hBF);
    wr_reg(8'hF8, 8'hE0);
    for (int j = 0; j < 5; j++) begin
      ext_s = 5'h01 << j;
      rd_reg(j < 4 ? 8'h91 : 8'hD8, j < 4 ? 8'h08 | (8'h10 << j) : 8'h48);
      ext_s = 5'h00;
      req_is(1'b1, 4'h6 + j[3:0], 1'b0);
      wr_reg(8'hE8, 8'hE0);
      req_is(1'b0, 4'hF, 1'b0);
      wr_reg(8'hE8, 8'hFF);
      wr_reg(8'hF8, 8'hE0 | (8'h01 << j));
      req_is(1'b1, 4'h6 + j[3:0], 1'b1);
      wr_reg(8'hF8, 8'hE0);
      wr_reg(j < 4 ? 8'h91 : 8'hD8, 8'h00);
    end
    wr_race(8'h91, 8'h00, 5'h01);
    rd_reg(8'h91, 8'h18);
    wr_race(8'hD8, 8'h00, 5'h10);
    rd_reg(8'hD8, 8'h48);
    wr_reg(8'h91, 8'h00);
    wr_reg(8'hD8, 8'h00);
    std_f = 7'h03;
    wr_reg(8'hB8, 8'h02);
    req_is(1'b1, 4'h1, 1'b1);
    svc(1'b1);
    req_is(1'b0, 4'hF, 1'b0);
    svc(1'b0);
    req_is(1'b1, 4'h1, 1'b1);
    wr_reg(8'hB8, 8'h00);
    req_is(1'b1, 4'h0, 1'b0);
    svc(1'b1);
    req_is(1'b0, 4'hF, 1'b0);
    wr_reg(8'hB8, 8'h01);
    req_is(1'b1, 4'h0, 1'b1);
    summarize();
  end
endmodule : irq_enable_priority_tb
